// ===== rtl/audio_rx_pkg.sv
`default_nettype none

package audio_rx_pkg;

  // ****************************************
  // link timing
  // ****************************************
  localparam int LINK_PERIOD_PS = 12000;
  localparam int DET_TIME_NS = 50000;
  localparam int IDLE_TIME_NS = 100000;
  // longest times, rounded down to whole link cycles
  localparam int DET_CYCLES = DET_TIME_NS * 1000 / LINK_PERIOD_PS;
  localparam int IDLE_CYCLES = IDLE_TIME_NS * 1000 / LINK_PERIOD_PS;
  localparam logic [2:0] LOCK_FRAMES = 3'h4;
  localparam logic [8:0] SYNC_MAX_HIGH = 9'h004;

  // ****************************************
  // frame widths in bit-clock periods
  // ****************************************
  localparam logic [8:0] LEN_TWO16 = 9'h020;
  localparam logic [8:0] LEN_TWO24 = 9'h030;
  localparam logic [8:0] LEN_TWO32 = 9'h040;
  localparam logic [8:0] LEN_TDM16 = 9'h080;
  localparam logic [8:0] LEN_TDM32 = 9'h100;
  localparam logic [8:0] FCNT_MAX = 9'h1ff;
  localparam logic [12:0] ECNT_MAX = 13'h1fff;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SAMPLE = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_STRAP_LSB = 1;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {MODE_NONE = 2'h0, MODE_TWO = 2'h1, MODE_TDM = 2'h2} mode_e;
  typedef enum logic [1:0] {ROLE_A = 2'h0, ROLE_B = 2'h1, ROLE_C = 2'h2} role_e;
  typedef enum logic [1:0] {STRAP_GND = 2'h0, STRAP_VDD = 2'h1, STRAP_OPEN = 2'h2} strap_e;
  typedef enum logic [3:0] {
    ST_STANDBY = 4'h1,
    ST_DETECT = 4'h2,
    ST_CHECK = 4'h4,
    ST_RUN = 4'h8
  } link_state_e;

endpackage

`default_nettype wire

// ===== rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop level synchroniser
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  if (W < 1) begin : g_bad_w
    $error("pin_sync: width must be at least 1");
  end

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/pcm_tdm_audio_receiver.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - 50% frame clock selects two-channel framing
// - high four periods or less selects TDM
// - two-channel frames are 32, 48 or 64
// - TDM frames are 128 or 256 periods
// - two-channel data sampled on rising edge
// - TDM edge: rising standard, falling left-justified
// - standard-delay: frame clock low is left
// - left-justified: frame clock high is left
// - standard-delay word starts one bit late
// - left-justified word starts at transition
// - assignment A forwards left word
// - assignment B forwards right word
// - assignment C forwards half left plus half right
// - fastest pin is bit clock, three rotations
// - lock after four valid frames, else restart
// - TDM slot from assignment and strap
module pcm_tdm_audio_receiver #(
  parameter bit LEFT_JUSTIFIED = 1'b0,
  parameter int SAMPLE_W = 24,
  parameter int DET_CYCLES = audio_rx_pkg::DET_CYCLES,
  parameter int IDLE_CYCLES = audio_rx_pkg::IDLE_CYCLES
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin sampling clock
  input wire logic link_clk,
  // audio interface pins
  input wire logic audio_pin_zero,
  input wire logic audio_pin_one,
  input wire logic audio_pin_two,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // amplifier path
  output logic amp_on,
  output logic [SAMPLE_W-1:0] amp_sample,
  output logic amp_sample_valid
);

  if (SAMPLE_W < 16 || SAMPLE_W > 32 || DET_CYCLES < 64 || DET_CYCLES > 65535 ||
      IDLE_CYCLES < 64 || IDLE_CYCLES > 65535) begin : g_bad_param
    $error("pcm_tdm_audio_receiver: parameter out of range");
  end

  function automatic logic pick(input logic [2:0] v, input logic [1:0] i);
    pick = (i == 2'h0) ? v[0] : ((i == 2'h1) ? v[1] : v[2]);
  endfunction

  function automatic logic [1:0] rot(input logic [1:0] i);
    rot = (i == 2'h2) ? 2'h0 : 2'(i + 2'h1);
  endfunction

  // ****************************************
  // link domain reset and pin capture
  // ****************************************
  logic [1:0] lrst_q;
  logic link_rst_n;
  logic [2:0] pin_s, pin_p_q, pin_edge;
  logic [2:0] ctrl_q, ctrl_l;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) lrst_q <= 2'h0;
    else lrst_q <= {lrst_q[0], 1'b1};
  end
  assign link_rst_n = lrst_q[1];

  pin_sync #(.W(3)) u_pins (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({audio_pin_two, audio_pin_one, audio_pin_zero}),
    .q(pin_s)
  );
  pin_sync #(.W(3)) u_ctrl (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d(ctrl_q),
    .q(ctrl_l)
  );

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) pin_p_q <= 3'h0;
    else pin_p_q <= pin_s;
  end
  assign pin_edge = pin_s ^ pin_p_q;

  wire en_l = ctrl_l[audio_rx_pkg::CTRL_EN_BIT];
  wire [1:0] strap_l = ctrl_l[audio_rx_pkg::CTRL_STRAP_LSB +: 2];

  // ****************************************
  // bit clock detection
  // ****************************************
  audio_rx_pkg::link_state_e st_q, st_d;
  logic [12:0] ecnt_q [3];
  logic [15:0] win_q, idle_q;
  logic [1:0] bsel_q, best;

  wire in_det = (st_q == audio_rx_pkg::ST_DETECT);
  wire active = (st_q == audio_rx_pkg::ST_CHECK) || (st_q == audio_rx_pkg::ST_RUN);
  wire win_end = in_det && (win_q == 16'(DET_CYCLES - 1));
  wire idle_end = active && (idle_q == 16'(IDLE_CYCLES - 1));
  wire any_edge = (ecnt_q[0] != 13'h0) || (ecnt_q[1] != 13'h0) || (ecnt_q[2] != 13'h0);

  for (genvar i = 0; i < 3; i++) begin : g_ecnt
    always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) ecnt_q[i] <= 13'h0;
      else if (!in_det) ecnt_q[i] <= 13'h0;
      else if (pin_edge[i] && ecnt_q[i] != audio_rx_pkg::ECNT_MAX) ecnt_q[i] <= 13'(ecnt_q[i] + 13'h1);
    end
  end

  // fastest toggling pin wins
  assign best = (ecnt_q[0] >= ecnt_q[1] && ecnt_q[0] >= ecnt_q[2]) ? 2'h0 :
                ((ecnt_q[1] >= ecnt_q[2]) ? 2'h1 : 2'h2);

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      win_q <= 16'h0;
      idle_q <= 16'h0;
      bsel_q <= 2'h0;
    end else begin
      win_q <= in_det ? 16'(win_q + 16'h1) : 16'h0;
      idle_q <= (!active || pin_edge != 3'h0) ? 16'h0 : 16'(idle_q + 16'h1);
      if (win_end) bsel_q <= best;
    end
  end

  // frame clock and data follow the bit clock in rotation
  wire [1:0] lr_idx = rot(bsel_q);
  wire [1:0] din_idx = rot(lr_idx);
  wire bclk = pick(pin_s, bsel_q);
  wire bclk_p = pick(pin_p_q, bsel_q);
  wire lr = pick(pin_s, lr_idx);
  wire din = pick(pin_s, din_idx);
  wire rise = bclk & ~bclk_p;
  wire fall = ~bclk & bclk_p;

  // ****************************************
  // frame measurement
  // ****************************************
  logic lrr_q, seen_q;
  logic [8:0] fcnt_q, hcnt_q, len_q;
  logic [2:0] vcnt_q;
  audio_rx_pkg::mode_e mode_q;

  wire lr_up = rise & lr & ~lrr_q;
  wire frame_evt = lr_up & seen_q;
  wire [8:0] fr_len = 9'(fcnt_q + 9'h1);
  wire fr_tdm = (hcnt_q <= audio_rx_pkg::SYNC_MAX_HIGH) &&
                (fr_len == audio_rx_pkg::LEN_TDM16 || fr_len == audio_rx_pkg::LEN_TDM32);
  wire fr_two = ({1'b0, fr_len} == {hcnt_q, 1'b0}) && (fr_len == audio_rx_pkg::LEN_TWO16 ||
                fr_len == audio_rx_pkg::LEN_TWO24 || fr_len == audio_rx_pkg::LEN_TWO32);
  wire fr_ok = fr_tdm | fr_two;
  wire [1:0] fr_mode = fr_tdm ? audio_rx_pkg::MODE_TDM : audio_rx_pkg::MODE_TWO;
  wire match = (fr_len == len_q) && (fr_mode == mode_q);
  wire overrun = active && (fcnt_q == audio_rx_pkg::FCNT_MAX);
  wire bad = overrun | (frame_evt & (~fr_ok | ((st_q == audio_rx_pkg::ST_RUN) & ~match)));
  wire lock = (st_q == audio_rx_pkg::ST_CHECK) && frame_evt && fr_ok && match &&
              (vcnt_q == 3'(audio_rx_pkg::LOCK_FRAMES - 3'h1));

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lrr_q <= 1'b0;
      seen_q <= 1'b0;
      fcnt_q <= 9'h0;
      hcnt_q <= 9'h0;
    end else if (!active) begin
      seen_q <= 1'b0;
      fcnt_q <= 9'h0;
      hcnt_q <= 9'h0;
    end else if (rise) begin
      lrr_q <= lr;
      if (lr_up) seen_q <= 1'b1;
      fcnt_q <= lr_up ? 9'h0 : (overrun ? fcnt_q : 9'(fcnt_q + 9'h1));
      if (lr_up) hcnt_q <= 9'h1;
      else if (lr && hcnt_q != audio_rx_pkg::FCNT_MAX) hcnt_q <= 9'(hcnt_q + 9'h1);
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      vcnt_q <= 3'h0;
      len_q <= 9'h0;
      mode_q <= audio_rx_pkg::MODE_NONE;
    end else if (st_q == audio_rx_pkg::ST_CHECK && frame_evt) begin
      vcnt_q <= !fr_ok ? 3'h0 : ((vcnt_q == 3'h0 || match) ? 3'(vcnt_q + 3'h1) : 3'h1);
      len_q <= fr_len;
      mode_q <= audio_rx_pkg::mode_e'(fr_mode);
    end else if (!active) begin
      vcnt_q <= 3'h0;
    end
  end

  // ****************************************
  // detection sequence
  // ****************************************
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      audio_rx_pkg::ST_STANDBY: if (en_l && pin_edge != 3'h0) st_d = audio_rx_pkg::ST_DETECT;
      audio_rx_pkg::ST_DETECT: begin
        if (!en_l) st_d = audio_rx_pkg::ST_STANDBY;
        else if (win_end) st_d = any_edge ? audio_rx_pkg::ST_CHECK : audio_rx_pkg::ST_STANDBY;
      end
      audio_rx_pkg::ST_CHECK: begin
        if (!en_l || idle_end) st_d = audio_rx_pkg::ST_STANDBY;
        else if (bad) st_d = audio_rx_pkg::ST_DETECT;
        else if (lock) st_d = audio_rx_pkg::ST_RUN;
      end
      audio_rx_pkg::ST_RUN: begin
        if (!en_l || idle_end) st_d = audio_rx_pkg::ST_STANDBY;
        else if (bad) st_d = audio_rx_pkg::ST_DETECT;
      end
      default: st_d = audio_rx_pkg::ST_STANDBY;
    endcase
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) st_q <= audio_rx_pkg::ST_STANDBY;
    else st_q <= st_d;
  end

  // ****************************************
  // serial data capture
  // ****************************************
  logic lrs_q, sp_q;
  logic [5:0] bidx_q;
  logic [2:0] slot_q;
  logic [31:0] sr_q;
  logic [SAMPLE_W-1:0] hold_q, pkt_smp_q;
  logic [3:0] pkt_info_q;
  logic tgl_q;

  wire tdm = (mode_q == audio_rx_pkg::MODE_TDM);
  wire se = (tdm && LEFT_JUSTIFIED) ? fall : rise;
  wire frame_st = lr & ~lrs_q;
  wire eff_start = LEFT_JUSTIFIED ? frame_st : sp_q;
  wire [5:0] swid = tdm ? len_q[8:3] : len_q[6:1];
  wire wrap = (bidx_q == 6'(swid - 6'h1));
  wire [5:0] cur_idx = (eff_start || wrap) ? 6'h0 : 6'(bidx_q + 6'h1);
  wire [2:0] cur_slot = eff_start ? 3'h0 : (wrap ? 3'(slot_q + 3'h1) : slot_q);
  wire done = se && (cur_idx == 6'(swid - 6'h1));
  wire [31:0] word = {sr_q[30:0], din};
  wire [31:0] just = word << (6'h20 - swid);
  wire [SAMPLE_W-1:0] samp = just[31 -: SAMPLE_W];
  wire [SAMPLE_W-1:0] half = {samp[SAMPLE_W-1], samp[SAMPLE_W-1:1]};
  wire [SAMPLE_W-1:0] mix = SAMPLE_W'(hold_q + half);
  // frame clock high half is slot 0
  wire is_left = ((cur_slot[0] == 1'b0) == LEFT_JUSTIFIED);

  function automatic logic [3:0] tdm_slot(input logic [1:0] role, input logic [1:0] strap);
    tdm_slot = 4'h0;
    unique case ({role, strap})
      {audio_rx_pkg::ROLE_A, audio_rx_pkg::STRAP_GND}: tdm_slot = 4'h8;
      {audio_rx_pkg::ROLE_A, audio_rx_pkg::STRAP_VDD}: tdm_slot = 4'h9;
      {audio_rx_pkg::ROLE_A, audio_rx_pkg::STRAP_OPEN}: tdm_slot = 4'ha;
      {audio_rx_pkg::ROLE_B, audio_rx_pkg::STRAP_VDD}: tdm_slot = 4'hb;
      {audio_rx_pkg::ROLE_B, audio_rx_pkg::STRAP_GND}: tdm_slot = 4'hc;
      {audio_rx_pkg::ROLE_C, audio_rx_pkg::STRAP_GND}: tdm_slot = 4'hd;
      {audio_rx_pkg::ROLE_C, audio_rx_pkg::STRAP_OPEN}: tdm_slot = 4'he;
      {audio_rx_pkg::ROLE_C, audio_rx_pkg::STRAP_VDD}: tdm_slot = 4'hf;
      default: tdm_slot = 4'h0;
    endcase
  endfunction

  wire [3:0] tsel = tdm_slot(bsel_q, strap_l);
  wire em_tdm = tdm && tsel[3] && (cur_slot == tsel[2:0]);
  wire em_a = !tdm && (bsel_q == audio_rx_pkg::ROLE_A) && is_left;
  wire em_b = !tdm && (bsel_q == audio_rx_pkg::ROLE_B) && !is_left;
  wire em_c = !tdm && (bsel_q == audio_rx_pkg::ROLE_C) && cur_slot[0];
  wire emit = (st_q == audio_rx_pkg::ST_RUN) && done && (em_tdm || em_a || em_b || em_c);

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lrs_q <= 1'b0;
      sp_q <= 1'b0;
      bidx_q <= 6'h0;
      slot_q <= 3'h0;
      sr_q <= 32'h0;
    end else if (se) begin
      lrs_q <= lr;
      sp_q <= frame_st;
      bidx_q <= cur_idx;
      slot_q <= cur_slot;
      sr_q <= word;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      hold_q <= '0;
      pkt_smp_q <= '0;
      pkt_info_q <= 4'h0;
      tgl_q <= 1'b0;
    end else begin
      if (done && !tdm && !cur_slot[0]) hold_q <= half;
      if (emit) begin
        pkt_smp_q <= em_c ? mix : samp;
        pkt_info_q <= {mode_q, bsel_q};
        tgl_q <= ~tgl_q;
      end
    end
  end

  // ****************************************
  // link to system crossing
  // ****************************************
  logic [1:0] xs;
  logic tgl_p_q, valid_q, locked_q;
  logic [SAMPLE_W-1:0] smp_q;
  logic [3:0] info_q;

  pin_sync #(.W(2)) u_xing (
    .clk(clk),
    .rst_n(rst_n),
    .d({tgl_q, st_q == audio_rx_pkg::ST_RUN}),
    .q(xs)
  );

  wire new_smp = xs[1] ^ tgl_p_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_p_q <= 1'b0;
      valid_q <= 1'b0;
      locked_q <= 1'b0;
      smp_q <= '0;
      info_q <= 4'h0;
    end else begin
      tgl_p_q <= xs[1];
      valid_q <= new_smp;
      locked_q <= xs[0];
      if (new_smp) begin
        smp_q <= pkt_smp_q;
        info_q <= pkt_info_q;
      end
    end
  end

  assign amp_on = locked_q;
  assign amp_sample = smp_q;
  assign amp_sample_valid = valid_q;

  // ****************************************
  // register slave
  // ****************************************
  logic aw_q, w_q, bv_q, rv_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q, rd_q;
  logic [3:0] ws_q;
  logic [1:0] br_q, rr_q;

  wire do_wr = aw_q && w_q && !bv_q;
  wire do_rd = s_axi_arvalid && !rv_q;
  wire wr_hit = (awa_q == audio_rx_pkg::ADDR_CTRL);
  wire rd_hit = (s_axi_araddr == audio_rx_pkg::ADDR_CTRL) || (s_axi_araddr == audio_rx_pkg::ADDR_STATUS) ||
                (s_axi_araddr == audio_rx_pkg::ADDR_SAMPLE);
  wire [31:0] rd_mux = (s_axi_araddr == audio_rx_pkg::ADDR_CTRL) ? {29'h0, ctrl_q} :
                       (s_axi_araddr == audio_rx_pkg::ADDR_STATUS) ? {27'h0, info_q, locked_q} :
                       (s_axi_araddr == audio_rx_pkg::ADDR_SAMPLE) ?
                       {{(32 - SAMPLE_W){smp_q[SAMPLE_W-1]}}, smp_q} : 32'h0;

  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_q) awa_q <= s_axi_awaddr;
      if (s_axi_wvalid && !w_q) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      aw_q <= do_wr ? 1'b0 : (aw_q | s_axi_awvalid);
      w_q <= do_wr ? 1'b0 : (w_q | s_axi_wvalid);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bv_q <= 1'b0;
      br_q <= audio_rx_pkg::RESP_OKAY;
      ctrl_q <= audio_rx_pkg::CTRL_RESET;
    end else begin
      if (do_wr) begin
        bv_q <= 1'b1;
        br_q <= (wr_hit || awa_q == audio_rx_pkg::ADDR_STATUS || awa_q == audio_rx_pkg::ADDR_SAMPLE) ?
                audio_rx_pkg::RESP_OKAY : audio_rx_pkg::RESP_SLVERR;
        if (wr_hit && ws_q[0]) ctrl_q <= wd_q[2:0];
      end else if (s_axi_bready) begin
        bv_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rv_q <= 1'b0;
      rd_q <= 32'h0;
      rr_q <= audio_rx_pkg::RESP_OKAY;
    end else if (do_rd) begin
      rv_q <= 1'b1;
      rd_q <= rd_mux;
      rr_q <= rd_hit ? audio_rx_pkg::RESP_OKAY : audio_rx_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rv_q <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_run_bad;
    st_q == audio_rx_pkg::ST_RUN && bad && en_l && !idle_end;
  endsequence

  a_drop_on_bad: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    s_run_bad |=> st_q == audio_rx_pkg::ST_DETECT) else $error("bad frame did not restart detection");
  a_lock_four_frames: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $rose(st_q == audio_rx_pkg::ST_RUN) |-> $past(vcnt_q) == 3'h3) else $error("locked early");
  a_two_width: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (st_q == audio_rx_pkg::ST_RUN && !tdm) |-> (len_q == 9'h020 || len_q == 9'h030 || len_q == 9'h040))
    else $error("bad two-channel width");
  a_tdm_width: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (st_q == audio_rx_pkg::ST_RUN && tdm) |-> (len_q == 9'h080 || len_q == 9'h100)) else $error("bad tdm width");
  a_sync_pulse: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (lock && fr_mode == audio_rx_pkg::MODE_TDM) |-> hcnt_q <= 9'h004) else $error("tdm sync too long");
  a_tdm_edge: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (se && tdm) |-> (LEFT_JUSTIFIED ? !bclk : bclk)) else $error("tdm sampled on wrong edge");
  a_two_edge: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (se && !tdm) |-> bclk && !bclk_p) else $error("two-channel sampled on falling edge");
  a_slot_pick: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (emit && tdm) |-> tsel[3] && cur_slot == tsel[2:0]) else $error("wrong tdm slot");
  a_mix_out: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (emit && em_c) |=> pkt_smp_q == $past(mix)) else $error("mono mix wrong");
  a_msb_first: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (emit && !em_c) |=> pkt_smp_q == $past(word[31:32-SAMPLE_W]) || swid != 6'h20) else $error("msb order");
  a_valid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    new_smp |=> amp_sample_valid ##1 !amp_sample_valid) else $error("sample valid not one cycle");

endmodule

`default_nettype wire

// ===== verification/audio_host.sv
`timescale 1ns/1ps
`default_nettype none

// ****************
// host audio source
// ****************
module audio_host #(
  parameter bit LJ = 1'b0
) (
  // frame control
  input wire logic run,
  input wire logic [1:0] role,
  input wire logic tdm,
  input wire logic [5:0] w,
  input wire logic [2:0] slot,
  input wire logic [31:0] left,
  input wire logic [31:0] right,
  // pins
  output logic pin0,
  output logic pin1,
  output logic pin2
);
  logic b, l, d, nl, nd;
  int n, k;
  initial begin
    b = 1'b0;
    l = 1'b0;
    d = 1'b0;
    forever begin
      wait (run);
      n = tdm ? 8 * w : 2 * w;
      for (int i = 0; i < n; i++) begin
        k = LJ ? i : (i + n - 1) % n;
        nl = tdm ? i == 0 : (i >= w) != LJ;
        nd = (tdm ? k / w == slot : k < w) ? left[w - 1 - k % w] : right[w - 1 - k % w];
        // falling-edge tdm changes lines after the rise
        if (!(LJ && tdm)) begin
          l = nl;
          d = nd;
        end
        #(10416.67 / n) b = 1'b1;
        l = nl;
        d = nd;
        #(10416.67 / n) b = 1'b0;
      end
      if (!run) begin
        l = 1'b0;
        d = 1'b0;
      end
    end
  end
  assign pin0 = role == 2'h0 ? b : (role == 2'h1 ? d : l);
  assign pin1 = role == 2'h0 ? l : (role == 2'h1 ? b : d);
  assign pin2 = role == 2'h0 ? d : (role == 2'h1 ? l : b);
endmodule

`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [31:0] LW = 32'h1234_5678;
  localparam logic [31:0] RW = 32'h8765_4321;
  logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, run = 1'b0, tdm = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [1:0] role = 2'h0;
  logic [5:0] w = 6'h10;
  logic [2:0] slot = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, amp_on, amp_sample_valid, p0, p1, p2, p3, p4, p5, lj_on, lj_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] amp_sample, lj_sample;
  logic [1:0] st [8] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0, 2'h2, 2'h1};
  int fails = 0, n_tests = 0;

  always #20 clk = ~clk;
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end

  audio_host audio_host_i (.run(run), .role(role), .tdm(tdm), .w(w), .slot(slot), .left(LW), .right(RW),
    .pin0(p0), .pin1(p1), .pin2(p2));
  audio_host #(.LJ(1'b1)) audio_host_lj_i (.run(run), .role(role), .tdm(tdm), .w(w), .slot(slot), .left(LW),
    .right(RW), .pin0(p3), .pin1(p4), .pin2(p5));
  pcm_tdm_audio_receiver #(.DET_CYCLES(512), .IDLE_CYCLES(2048)) pcm_tdm_audio_receiver_i (.clk(clk),
    .rst_n(rst_n), .link_clk(link_clk), .audio_pin_zero(p0), .audio_pin_one(p1), .audio_pin_two(p2),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .amp_on(amp_on), .amp_sample(amp_sample), .amp_sample_valid(amp_sample_valid));
  pcm_tdm_audio_receiver #(.LEFT_JUSTIFIED(1'b1), .DET_CYCLES(512), .IDLE_CYCLES(2048))
    pcm_tdm_audio_receiver_lj_i (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .audio_pin_zero(p3),
    .audio_pin_one(p4), .audio_pin_two(p5), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready), .amp_on(lj_on),
    .amp_sample(lj_sample), .amp_sample_valid(lj_valid));

  // ****************
  // helpers
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic logic [23:0] cut(input logic [31:0] v, input int n);
    logic [31:0] x;
    x = v << (32 - n);
    return x[31:8];
  endfunction

  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      da = da | awready;
      dw = dw | wready;
      @(posedge clk);
      if (da) awvalid <= 1'b0;
      if (dw) wvalid <= 1'b0;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic reg_test;
    logic [31:0] d;
    logic [1:0] r;
    axr(audio_rx_pkg::ADDR_CTRL, d, r);
    check(d, 32'h0, "ctrl reset");
    axw(audio_rx_pkg::ADDR_STATUS, 32'hffff_ffff, r);
    axr(audio_rx_pkg::ADDR_STATUS, d, r);
    check(d, 32'h0, "status idle");
    axw(8'h0c, 32'h1, r);
    check({30'h0, r}, {30'h0, audio_rx_pkg::RESP_SLVERR}, "unmapped write");
    axr(8'h0c, d, r);
    check({d[29:0], r}, {30'h0, audio_rx_pkg::RESP_SLVERR}, "unmapped read");
    $display("register test done");
  endtask

  task automatic link_case(input logic [1:0] rl, input logic t, input logic [5:0] ww, input logic [2:0] sl,
      input logic [1:0] sp, input logic [23:0] e);
    logic [31:0] d;
    logic [1:0] r;
    realtime t0;
    int k;
    axw(audio_rx_pkg::ADDR_CTRL, {29'h0, sp, 1'b1}, r);
    axr(audio_rx_pkg::ADDR_CTRL, d, r);
    check(d, {29'h0, sp, 1'b1}, "ctrl readback");
    role <= rl;
    tdm <= t;
    w <= ww;
    slot <= sl;
    run <= 1'b1;
    t0 = $realtime;
    k = 0;
    do @(negedge clk); while ({amp_on, lj_on} !== 2'h3 && ++k < 6000);
    check({31'h0, amp_on}, 32'h1, "locked");
    check({31'h0, lj_on}, 32'h1, "left-justified locked");
    check(32'(($realtime - t0) > 83333.0), 32'h1, "lock time");
    repeat (2) begin
      @(negedge clk);
      k = 0;
      do @(negedge clk); while (amp_sample_valid !== 1'b1 && ++k < 2000);
    end
    check({8'h0, amp_sample}, {8'h0, e}, "sample");
    repeat (2) begin
      @(negedge clk);
      k = 0;
      do @(negedge clk); while (lj_valid !== 1'b1 && ++k < 2000);
    end
    check({8'h0, lj_sample}, {8'h0, e}, "left-justified sample");
    axr(audio_rx_pkg::ADDR_STATUS, d, r);
    check({27'h0, d[4:0]}, {27'h0, t ? 2'h2 : 2'h1, rl, 1'b1}, "status");
    axr(audio_rx_pkg::ADDR_SAMPLE, d, r);
    check(d, {{8{e[23]}}, e}, "sample reg");
    run <= 1'b0;
    k = 0;
    do @(negedge clk); while ({amp_on, lj_on} !== 2'h0 && ++k < 3000);
    check({31'h0, amp_on}, 32'h0, "standby");
    check({31'h0, lj_on}, 32'h0, "left-justified standby");
    $display("link case role %0d tdm %0b width %0d done", rl, t, ww);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    reg_test();
    link_case(2'h0, 1'b0, 6'h10, 3'h0, 2'h0, cut(LW, 16));
    link_case(2'h1, 1'b0, 6'h18, 3'h0, 2'h0, cut(RW, 24));
    link_case(2'h2, 1'b0, 6'h20, 3'h0, 2'h0,
      24'(($signed(cut(LW, 32)) >>> 1) + ($signed(cut(RW, 32)) >>> 1)));
    for (int i = 0; i < 8; i++) begin
      link_case(i < 3 ? 2'h0 : (i < 5 ? 2'h1 : 2'h2), 1'b1, i[0] ? 6'h20 : 6'h10, 3'(i), st[i],
        cut(LW, i[0] ? 32 : 16));
    end
    complete_run();
  end

  initial begin
    #4ms;
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule

`default_nettype wire
